// *** hsc_cfg_host.sv ***
// Configuration byte writer standing in for the EEPROM loader or SMBus host
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"
module hsc_cfg_host (
  // Clock
  input wire logic ref_clk_i,
  // Configuration byte port
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_wdata_o,
  input wire logic [7:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i
);
  initial begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end

  // One idle cycle between strobes, so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // A real loader never programs a string longer than 64 bytes
    if ((a == `HSC_OFS_MAKER_LEN || a == `HSC_OFS_PROD_LEN) && v[6:0] > 7'h40) v = {v[7], 7'h40};
    @(posedge ref_clk_i);
    cfg_wr_o <= 1'b1;
    cfg_addr_o <= a;
    cfg_wdata_o <= v;
    @(posedge ref_clk_i);
    cfg_wr_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk_i);
    cfg_rd_o <= 1'b1;
    cfg_addr_o <= a;
    @(posedge ref_clk_i);
    cfg_rd_o <= 1'b0;
    #1;
    ok = cfg_rvalid_i;
    d = cfg_rdata_i;
  endtask
endmodule
`default_nettype wire

// *** hsc_defines.svh ***
// Offsets, field positions and reset values of the string descriptor register bank
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

`define HSC_OFS_MAKER_LEN 8'h23
`define HSC_OFS_PROD_LEN 8'h24
`define HSC_OFS_RESERVED_STRAP_A_STRAP 8'h2F
`define HSC_OFS_SERIAL_LO 8'h30
`define HSC_OFS_SERIAL_HI 8'h4F
`define HSC_OFS_MAKER_LO 8'h50
`define HSC_OFS_MAKER_HI 8'h8F
`define HSC_OFS_PROD_LO 8'h90
`define HSC_OFS_PROD_HI 8'hCF
`define HSC_OFS_FEATURE 8'hF0

`define HSC_LEN_MSB 6
`define HSC_LEN_RESET 7'h00
`define HSC_BYTE_RESET 8'h00
`define HSC_BIT_RESET 1'b0

`define HSC_SERIAL_BYTES 32
`define HSC_TEXT_BYTES 64
`define HSC_SERIAL_LEN 7'h20
`define HSC_DIE_ID_BITS 128

`define HSC_IDX_SERIAL 8'h01
`define HSC_IDX_PRODUCT 8'h02
`define HSC_IDX_MAKER 8'h03

`define HSC_SYNC_WAIT 2'h2

`endif

// *** hsc_pkg.sv ***
// Types shared by the string descriptor register bank modules
package hsc_pkg;

  typedef enum logic [1:0] {
    HSC_KIND_SERIAL = 2'b00,
    HSC_KIND_MAKER = 2'b01,
    HSC_KIND_PRODUCT = 2'b10
  } hsc_kind_t;

  typedef enum logic [1:0] {
    HSC_ST_SYNC = 2'b00,
    HSC_ST_LOAD = 2'b01,
    HSC_ST_RUN = 2'b10
  } hsc_state_t;

endpackage

// *** hsc_regs.sv ***
// Hub string descriptor configuration register bank with string byte server
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"
module hsc_regs (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Configuration byte port from EEPROM loader or SMBus slave
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Straps and fused data
  input wire logic custom_serial_select_i,
  input wire logic [`HSC_DIE_ID_BITS-1:0] fused_die_store_i,
  input wire logic ss_suspend_pin_i,
  // String descriptor requests
  input wire logic str_req_i,
  input wire logic [7:0] str_index_i,
  input wire logic str_superspeed_i,
  output logic str_none_o,
  output logic str_valid_o,
  output logic [7:0] str_data_o,
  output logic str_last_o,
  // Configuration outputs
  output logic superspeed_ssc_disable_o,
  output logic reserved_strap_o,
  output logic init_done_o
);
  import hsc_pkg::*;

  hsc_state_t state;
  hsc_state_t next_state;
  logic [1:0] sync_wait;
  logic ss_pin_sync;

  logic [6:0] maker_text_length;
  logic [6:0] product_text_length;
  logic reserved_strap_a;
  logic superspeed_ssc_disable;
  logic [7:0] unit_serial_bytes [`HSC_SERIAL_BYTES];
  logic [7:0] maker_text_bytes [`HSC_TEXT_BYTES];
  logic [7:0] product_text_bytes [`HSC_TEXT_BYTES];

  logic [7:0] serial_default [`HSC_SERIAL_BYTES];
  logic [7:0] serial_ofs;
  logic [7:0] maker_ofs;
  logic [7:0] prod_ofs;
  logic in_serial;
  logic in_maker;
  logic in_prod;
  logic wr_ok;

  logic req_take;
  hsc_kind_t req_kind;
  logic [6:0] req_len;
  logic req_serve;
  logic [7:0] read_mux;

  hsc_str_if str ();

  // Suspend pin crosses in from the board
  hsc_sync2 u_ss_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(ss_suspend_pin_i),
    .sync_o(ss_pin_sync)
  );

  // ASCII hex of each die identifier nibble; byte 0 is the top nibble
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'hA) ? {4'h3, nib} : {4'h4, nib - 4'h9};
  endfunction

  generate
    for (genvar g = 0; g < `HSC_SERIAL_BYTES; g++) begin : g_serial_default
      assign serial_default[g] = hex_char(fused_die_store_i[`HSC_DIE_ID_BITS-1-4*g -: 4]);
    end
  endgenerate

  // Start-up: wait for the synchronised strap, then load defaults once
  always_comb begin
    next_state = state;
    unique case (state)
      HSC_ST_SYNC: begin
        if (sync_wait == `HSC_SYNC_WAIT) begin
          next_state = HSC_ST_LOAD;
        end
      end
      HSC_ST_LOAD: begin
        next_state = HSC_ST_RUN;
      end
      HSC_ST_RUN: begin
        next_state = HSC_ST_RUN;
      end
      default: begin
        next_state = HSC_ST_SYNC;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= HSC_ST_SYNC;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_wait <= 2'h0;
    end else if (state == HSC_ST_SYNC) begin
      sync_wait <= sync_wait + 2'h1;
    end
  end

  assign init_done_o = (state == HSC_ST_RUN);

  // Address decode
  assign serial_ofs = cfg_addr_i - `HSC_OFS_SERIAL_LO;
  assign maker_ofs = cfg_addr_i - `HSC_OFS_MAKER_LO;
  assign prod_ofs = cfg_addr_i - `HSC_OFS_PROD_LO;
  assign in_serial = (cfg_addr_i >= `HSC_OFS_SERIAL_LO) && (cfg_addr_i <= `HSC_OFS_SERIAL_HI);
  assign in_maker = (cfg_addr_i >= `HSC_OFS_MAKER_LO) && (cfg_addr_i <= `HSC_OFS_MAKER_HI);
  assign in_prod = (cfg_addr_i >= `HSC_OFS_PROD_LO) && (cfg_addr_i <= `HSC_OFS_PROD_HI);
  // Writes during start-up would be overwritten by the default load
  assign wr_ok = cfg_wr_i && (state == HSC_ST_RUN);

  // Length fields keep only bits 6:0; bit 7 is never stored
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      maker_text_length <= `HSC_LEN_RESET;
      product_text_length <= `HSC_LEN_RESET;
    end else if (wr_ok) begin
      if (cfg_addr_i == `HSC_OFS_MAKER_LEN) begin
        maker_text_length <= cfg_wdata_i[`HSC_LEN_MSB:0];
      end
      if (cfg_addr_i == `HSC_OFS_PROD_LEN) begin
        product_text_length <= cfg_wdata_i[`HSC_LEN_MSB:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reserved_strap_a <= `HSC_BIT_RESET;
    end else if (wr_ok && cfg_addr_i == `HSC_OFS_RESERVED_STRAP_A_STRAP) begin
      reserved_strap_a <= cfg_wdata_i[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      superspeed_ssc_disable <= `HSC_BIT_RESET;
    end else if (state == HSC_ST_LOAD) begin
      superspeed_ssc_disable <= ss_pin_sync;
    end else if (wr_ok && cfg_addr_i == `HSC_OFS_FEATURE) begin
      superspeed_ssc_disable <= cfg_wdata_i[0];
    end
  end

  assign superspeed_ssc_disable_o = superspeed_ssc_disable;
  assign reserved_strap_o = reserved_strap_a;

  // Serial bytes: die-derived default, replaceable only with custom select
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `HSC_SERIAL_BYTES; i++) begin
        unit_serial_bytes[i] <= `HSC_BYTE_RESET;
      end
    end else if (state == HSC_ST_LOAD) begin
      for (int i = 0; i < `HSC_SERIAL_BYTES; i++) begin
        unit_serial_bytes[i] <= serial_default[i];
      end
    end else if (wr_ok && in_serial && custom_serial_select_i) begin
      unit_serial_bytes[serial_ofs[4:0]] <= cfg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `HSC_TEXT_BYTES; i++) begin
        maker_text_bytes[i] <= `HSC_BYTE_RESET;
      end
    end else if (wr_ok && in_maker) begin
      maker_text_bytes[maker_ofs[5:0]] <= cfg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `HSC_TEXT_BYTES; i++) begin
        product_text_bytes[i] <= `HSC_BYTE_RESET;
      end
    end else if (wr_ok && in_prod) begin
      product_text_bytes[prod_ofs[5:0]] <= cfg_wdata_i;
    end
  end

  // Read side; unmapped offsets and reserved bits read zero
  always_comb begin
    read_mux = 8'h00;
    if (cfg_addr_i == `HSC_OFS_MAKER_LEN) begin
      read_mux = {1'b0, maker_text_length};
    end else if (cfg_addr_i == `HSC_OFS_PROD_LEN) begin
      read_mux = {1'b0, product_text_length};
    end else if (cfg_addr_i == `HSC_OFS_RESERVED_STRAP_A_STRAP) begin
      read_mux = {7'h00, reserved_strap_a};
    end else if (cfg_addr_i == `HSC_OFS_FEATURE) begin
      read_mux = {7'h00, superspeed_ssc_disable};
    end else if (in_serial) begin
      read_mux = unit_serial_bytes[serial_ofs[4:0]];
    end else if (in_maker) begin
      read_mux = maker_text_bytes[maker_ofs[5:0]];
    end else if (in_prod) begin
      read_mux = product_text_bytes[prod_ofs[5:0]];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= read_mux;
      end
    end
  end

  // String request decode; requests while a string is streaming are dropped
  assign req_take = str_req_i && !str.busy && (state == HSC_ST_RUN);

  always_comb begin
    req_kind = HSC_KIND_SERIAL;
    req_len = 7'h00;
    if (str_index_i == `HSC_IDX_SERIAL && !str_superspeed_i) begin
      req_kind = HSC_KIND_SERIAL;
      req_len = `HSC_SERIAL_LEN;
    end else if (str_index_i == `HSC_IDX_PRODUCT) begin
      req_kind = HSC_KIND_PRODUCT;
      req_len = product_text_length;
    end else if (str_index_i == `HSC_IDX_MAKER) begin
      req_kind = HSC_KIND_MAKER;
      req_len = maker_text_length;
    end
  end

  assign req_serve = req_take && (req_len != 7'h00);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      str_none_o <= 1'b0;
    end else begin
      str_none_o <= req_take && (req_len == 7'h00);
    end
  end

  assign str.start = req_serve;
  assign str.kind = req_kind;
  assign str.len = req_len;

  // Kind is held for the whole walk so the byte source cannot switch mid-string
  hsc_kind_t walk_kind;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      walk_kind <= HSC_KIND_SERIAL;
    end else if (req_serve) begin
      walk_kind <= req_kind;
    end
  end

  always_comb begin
    str.byte_val = 8'h00;
    unique case (walk_kind)
      HSC_KIND_SERIAL: str.byte_val = unit_serial_bytes[str.byte_idx[4:0]];
      HSC_KIND_MAKER: str.byte_val = maker_text_bytes[str.byte_idx];
      HSC_KIND_PRODUCT: str.byte_val = product_text_bytes[str.byte_idx];
      default: str.byte_val = 8'h00;
    endcase
  end

  hsc_streamer u_streamer (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .str(str.walker),
    .byte_valid_o(str_valid_o),
    .byte_data_o(str_data_o),
    .byte_last_o(str_last_o)
  );

  sequence s_len_read;
    cfg_rd_i && (cfg_addr_i == `HSC_OFS_PROD_LEN || cfg_addr_i == `HSC_OFS_MAKER_LEN);
  endsequence

  sequence s_prod_request;
    req_take && str_index_i == `HSC_IDX_PRODUCT && product_text_length != 7'h00;
  endsequence

  sequence s_ss_serial_request;
    req_take && str_index_i == `HSC_IDX_SERIAL && str_superspeed_i;
  endsequence

  a_len_msb_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_len_read |=> cfg_rvalid_o && !cfg_rdata_o[7])
    else $error("reserved length bit read as one");

  a_prod_len_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state == HSC_ST_LOAD |-> product_text_length == 7'h00 && maker_text_length == 7'h00)
    else $error("length fields not zero after reset");

  a_prod_string_served: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_prod_request |-> ##2 str_valid_o && str_data_o == product_text_bytes[0])
    else $error("product string not served from byte zero");

  a_serial_locked: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cfg_wr_i && cfg_addr_i == `HSC_OFS_SERIAL_LO && !custom_serial_select_i && state == HSC_ST_RUN
    |=> $stable(unit_serial_bytes[0]))
    else $error("serial byte changed without custom select");

  a_no_ss_serial: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_ss_serial_request |=> str_none_o ##1 !str_valid_o)
    else $error("serial string served on superspeed request");

  a_strap_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state == HSC_ST_LOAD |=> superspeed_ssc_disable_o == $past(ss_pin_sync))
    else $error("suspend strap not captured into ssc disable");

  a_reserved_strap_a_strap_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_ok && cfg_addr_i == `HSC_OFS_RESERVED_STRAP_A_STRAP |=> reserved_strap_o == $past(cfg_wdata_i[0]))
    else $error("reserved strap bit not written");

  a_maker_len_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_ok && cfg_addr_i == `HSC_OFS_MAKER_LEN |=> maker_text_length == $past(cfg_wdata_i[6:0]))
    else $error("maker length not written");
endmodule
`default_nettype wire

// *** hsc_str_if.sv ***
// Link between the register bank and its string byte streamer
`timescale 1ns/1ps
`default_nettype none
interface hsc_str_if;
  import hsc_pkg::*;
  logic start;
  hsc_kind_t kind;
  logic [6:0] len;
  logic [5:0] byte_idx;
  logic [7:0] byte_val;
  logic busy;

  modport bank (output start, output kind, output len, input byte_idx, output byte_val, input busy);
  modport walker (input start, input kind, input len, output byte_idx, input byte_val, output busy);
endinterface
`default_nettype wire

// *** hsc_streamer.sv ***
// Walks a string array and emits its bytes one per cycle in ascending order
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"
module hsc_streamer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Bank side
  hsc_str_if.walker str,
  // Byte stream
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic byte_last_o
);
  import hsc_pkg::*;

  logic running;
  logic [6:0] count;
  logic [6:0] len_hold;
  logic [6:0] sent;

  assign str.busy = running;
  assign str.byte_idx = count[5:0];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      running <= 1'b0;
      count <= 7'h00;
      len_hold <= 7'h00;
    end else if (str.start && !running) begin
      running <= 1'b1;
      count <= 7'h00;
      len_hold <= str.len;
    end else if (running) begin
      count <= count + 7'h01;
      if (count == len_hold - 7'h01) begin
        running <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_valid_o <= 1'b0;
      byte_data_o <= 8'h00;
      byte_last_o <= 1'b0;
    end else begin
      byte_valid_o <= running;
      byte_data_o <= running ? str.byte_val : 8'h00;
      byte_last_o <= running && (count == len_hold - 7'h01);
    end
  end

  // Helper: bytes emitted in the current string
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sent <= 7'h00;
    end else if (byte_valid_o) begin
      sent <= byte_last_o ? 7'h00 : sent + 7'h01;
    end
  end

  a_count_matches_len: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    byte_valid_o && byte_last_o |-> sent + 7'h01 == len_hold)
    else $error("string byte count differs from programmed length");

  a_bytes_back_to_back: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    byte_valid_o && !byte_last_o |=> byte_valid_o)
    else $error("gap inside a string stream");
endmodule
`default_nettype wire

// *** hsc_sync2.sv ***
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module hsc_sync2 (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);
  import hsc_pkg::*;

  logic stage1;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the string descriptor register bank
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"
module tb_top;
  import hsc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic custom_sel = 1'b0;
  logic [`HSC_DIE_ID_BITS-1:0] die_id = '0;
  logic pin = 1'b0;
  logic str_req = 1'b0;
  logic [7:0] str_idx = 8'h00;
  logic str_ss = 1'b0;
  logic str_none, str_valid, str_last, ssc_dis, strap, init_done;
  logic [7:0] str_data;
  logic [7:0] q [$];
  int n_mismatch = 0;
  int check_count = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  hsc_cfg_host host (.ref_clk_i(ref_clk_i), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr),
    .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata), .cfg_rvalid_i(cfg_rvalid));

  hsc_regs DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
    .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid),
    .custom_serial_select_i(custom_sel), .fused_die_store_i(die_id), .ss_suspend_pin_i(pin),
    .str_req_i(str_req), .str_index_i(str_idx), .str_superspeed_i(str_ss), .str_none_o(str_none),
    .str_valid_o(str_valid), .str_data_o(str_data), .str_last_o(str_last),
    .superspeed_ssc_disable_o(ssc_dis), .reserved_strap_o(strap), .init_done_o(init_done));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk("read data", exp, d);
  endtask

  // Collects the answer to one request; bounded so a silent design cannot hang
  task automatic req(input logic [7:0] idx, input logic ss, output logic none);
    none = 1'b0;
    q.delete();
    @(posedge ref_clk_i);
    str_req <= 1'b1;
    str_idx <= idx;
    str_ss <= ss;
    @(posedge ref_clk_i);
    str_req <= 1'b0;
    for (int i = 0; i < 80; i++) begin
      #1;
      if (str_none === 1'b1) none = 1'b1;
      if (str_valid === 1'b1) q.push_back(str_data);
      if (str_none === 1'b1 || str_last === 1'b1) break;
      @(posedge ref_clk_i);
    end
  endtask

  task automatic schk(input logic [7:0] idx, input logic [7:0] exp [$]);
    logic none;
    req(idx, 1'b0, none);
    chk("string none", 8'h00, {7'h00, none});
    chk("string length", 8'(exp.size()), 8'(q.size()));
    foreach (exp[k]) chk("string byte", exp[k], (k < q.size()) ? q[k] : 8'hXX);
  endtask

  task automatic nchk(input logic [7:0] idx, input logic ss);
    logic none;
    req(idx, ss, none);
    chk("string none", 8'h01, {7'h00, none});
    chk("string length", 8'h00, 8'(q.size()));
  endtask

  // Serial default encoding: one upper-case ASCII hex digit per nibble
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  initial begin
    logic [7:0] e [$];
    logic [7:0] base;
    int len;
    void'($urandom(16858));
    die_id <= {$urandom, $urandom, $urandom, $urandom};
    pin <= 1'($urandom);
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 20 && init_done !== 1'b1; i++) @(posedge ref_clk_i);
    #1;
    chk("init done", 8'h01, {7'h00, init_done});
    chk("ssc pin capture", {7'h00, pin}, {7'h00, ssc_dis});
    rchk(`HSC_OFS_FEATURE, {7'h00, pin});
    rchk(`HSC_OFS_PROD_LEN, 8'h00);
    rchk(`HSC_OFS_MAKER_LEN, 8'h00);
    rchk(`HSC_OFS_RESERVED_STRAP_A_STRAP, 8'h00);
    rchk(8'h2E, 8'h00);
    for (int n = 0; n < 32; n++) rchk(8'h30 + 8'(n), hexc(die_id[127-4*n -: 4]));
    host.wr(`HSC_OFS_PROD_LEN, 8'hC0);
    rchk(`HSC_OFS_PROD_LEN, 8'h40);
    host.wr(`HSC_OFS_FEATURE, 8'hFF);
    rchk(`HSC_OFS_FEATURE, 8'h01);
    chk("ssc disable", 8'h01, {7'h00, ssc_dis});
    host.wr(`HSC_OFS_RESERVED_STRAP_A_STRAP, 8'hFF);
    rchk(`HSC_OFS_RESERVED_STRAP_A_STRAP, 8'h01);
    chk("reserved strap", 8'h01, {7'h00, strap});
    host.wr(`HSC_OFS_FEATURE, 8'h00);
    host.wr(`HSC_OFS_RESERVED_STRAP_A_STRAP, 8'h00);
    rchk(`HSC_OFS_FEATURE, 8'h00);
    chk("ssc disable", 8'h00, {7'h00, ssc_dis});
    chk("reserved strap", 8'h00, {7'h00, strap});
    host.wr(8'h30, 8'h5A);
    rchk(8'h30, hexc(die_id[127:124]));
    @(posedge ref_clk_i);
    custom_sel <= 1'b1;
    host.wr(8'h30, 8'h5A);
    rchk(8'h30, 8'h5A);
    e.delete();
    for (int n = 0; n < 32; n++) e.push_back((n == 0) ? 8'h5A : hexc(die_id[127-4*n -: 4]));
    schk(`HSC_IDX_SERIAL, e);
    nchk(`HSC_IDX_SERIAL, 1'b1);
    host.wr(`HSC_OFS_PROD_LEN, 8'h00);
    nchk(`HSC_IDX_PRODUCT, 1'b0);
    nchk(`HSC_IDX_MAKER, 1'b0);
    nchk(8'h04, 1'b0);
    for (int k = 0; k < 2; k++) begin
      for (int r = 0; r < 3; r++) begin
        base = k ? `HSC_OFS_PROD_LO : `HSC_OFS_MAKER_LO;
        len = (r == 0) ? 64 : (r == 1) ? 1 : 1 + $urandom_range(63);
        e.delete();
        for (int n = 0; n < len; n++) begin
          e.push_back(n[0] ? 8'h00 : 8'h20 + 8'($urandom_range(94)));
          host.wr(base + 8'(n), e[n]);
        end
        host.wr(k ? `HSC_OFS_PROD_LEN : `HSC_OFS_MAKER_LEN, 8'(len));
        rchk(k ? `HSC_OFS_PROD_LEN : `HSC_OFS_MAKER_LEN, 8'(len));
        schk(k ? `HSC_IDX_PRODUCT : `HSC_IDX_MAKER, e);
        rchk(base + 8'(len - 1), e[len-1]);
      end
    end
    test_done();
  end

  // Whole run is about a thousand cycles at most; the 20000-cycle limit leaves a wide margin
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
